// [lsfi_pkg.sv]
package lsfi_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] LSFI_OFS_STATUS  = 8'h00;
	localparam logic [7:0] LSFI_OFS_TXBUF0  = 8'h04;
	localparam logic [7:0] LSFI_OFS_TXBUF7  = 8'h20;
	localparam logic [7:0] LSFI_OFS_RXDATA  = 8'h24;
	localparam logic [7:0] LSFI_OFS_BASE_HI = 8'h28;
	localparam logic [7:0] LSFI_OFS_BASE_LO = 8'h2c;
	localparam logic [7:0] LSFI_OFS_SIZE    = 8'h30;
	localparam logic [7:0] LSFI_OFS_XSTATE  = 8'h34;

	// ==========================================================
	// Field positions and reset values
	localparam int         LSFI_BIT_TX_END  = 7;
	localparam int         LSFI_BIT_TX_PEND = 6;
	localparam int         LSFI_BIT_RX_END  = 5;
	localparam int         LSFI_RSV_MSB     = 4;
	localparam int         LSFI_WORD_LSB    = 2;
	localparam int         LSFI_TXBUF_CNT   = 8;
	localparam int         LSFI_RXBUF_CNT   = 4;
	localparam logic [7:0] LSFI_RST_BYTE    = 8'h00;
	localparam logic [2:0] LSFI_TX_LAST     = 3'h7;
	localparam logic [2:0] LSFI_RX_NONE     = 3'h0;
	localparam logic [2:0] LSFI_RX_MAX      = 3'h4;

	// ==========================================================
	// Host window decode
	localparam int         LSFI_WIN_LSB     = 20;
	localparam int         LSFI_FW_MSB      = 27;
	localparam int         LSFI_FADDR_W     = 23;
	localparam logic [3:0] LSFI_LO_IGNORE   = 4'h0;

	// ==========================================================
	// Bus side types
	typedef enum logic [1:0] {
		LSFI_SZ_1MB,
		LSFI_SZ_2MB,
		LSFI_SZ_4MB,
		LSFI_SZ_8MB
	} lsfi_size_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} lsfi_req_s;

	typedef struct packed {
		logic        valid;
		logic        fw;
		logic [3:0]  idsel;
		logic [31:0] addr;
	} lsfi_host_s;

	typedef struct packed {
		logic                    sync;
		logic [LSFI_FADDR_W-1:0] faddr;
	} lsfi_hit_s;

endpackage : lsfi_pkg

// [lsfi_ahb_slave.sv]
`timescale 1ns/1ps
module lsfi_ahb_slave
	import lsfi_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output lsfi_req_s        req
);

	// ==========================================================
	// One wait state per transfer so read data can be registered
	typedef struct packed {
		logic       pend;
		logic       wr;
		logic [7:0] addr;
		logic       busy;
		logic       rdy;
		lsfi_req_s  req;
	} lsfi_ahb_s;

	lsfi_ahb_s st_r, st_nxt;

	always_comb begin
		st_nxt         = st_r;
		st_nxt.req.wr  = 1'b0;
		st_nxt.req.rd  = 1'b0;
		st_nxt.rdy     = 1'b1;
		if (st_r.pend) begin
			st_nxt.pend = 1'b0;
			st_nxt.busy = 1'b1;
			// Writes wait for hwdata, which stands only in the data phase
			if (st_r.wr) begin
				st_nxt.req.wr    = 1'b1;
				st_nxt.req.addr  = st_r.addr;
				st_nxt.req.wdata = hwdata;
			end
		end else if (st_r.busy) begin
			st_nxt.busy = 1'b0;
		end
		if (hsel && htrans[1] && hready && !st_r.pend) begin
			st_nxt.pend = 1'b1;
			st_nxt.wr   = hwrite;
			st_nxt.addr = haddr[7:0];
			st_nxt.rdy  = 1'b0;
			// Reads start at once so the registered data stands when the wait state ends
			if (!hwrite) begin
				st_nxt.req.rd   = 1'b1;
				st_nxt.req.addr = haddr[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r     <= '0;
			st_r.rdy <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hreadyout = st_r.rdy;
	assign req       = st_r.req;

endmodule : lsfi_ahb_slave

// [lsfi_host_decode.sv]
`timescale 1ns/1ps
module lsfi_host_decode
	import lsfi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  lsfi_host_s      host,
	input  wire logic [7:0] base_hi,
	input  wire logic [7:0] base_lo,
	input  lsfi_size_e      size_sel,
	output lsfi_hit_s       hit
);

	// ==========================================================
	// Window compare, registered one cycle after the request
	typedef struct packed {
		lsfi_hit_s hit;
	} lsfi_dec_s;

	lsfi_dec_s   st_r, st_nxt;
	logic [31:0] base;
	logic [31:0] addr;
	logic [31:0] diff;
	logic [31:0] span;
	logic        id_ok;

	always_comb begin
		base  = {base_hi, base_lo[7:4], LSFI_LO_IGNORE, 16'h0000}; // RULE_13 RULE_16
		addr  = host.addr;
		id_ok = 1'b1;
		if (host.fw) begin
			// Firmware cycles carry the select code instead of the top nibble
			base[31:28] = 4'h0;
			addr[31:28] = 4'h0;
			id_ok       = (host.idsel == base_hi[7:4]); // RULE_15
		end
		diff = addr - base; // RULE_21
		span = 32'h0010_0000 << size_sel; // RULE_18
		st_nxt.hit.sync  = host.valid && id_ok && (addr >= base) && (diff < span); // RULE_14
		st_nxt.hit.faddr = diff[LSFI_FADDR_W-1:0] & span[LSFI_FADDR_W-1:0] - 23'h1; // RULE_21
		if (!host.valid) begin
			st_nxt.hit.faddr = st_r.hit.faddr;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hit = st_r.hit;

endmodule : lsfi_host_decode

// [lsfi_regs.sv]
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
// Function
// [RULE_01] Set transmit-end once write data shifted out
// [RULE_02] Clear transmit-end by read one, write zero
// [RULE_03] Transmit-pending set on enable, cleared on done
// [RULE_04] Set receive-end when flash data arrives
// [RULE_05] Idle: clear receive-end when count hits zero
// [RULE_06] Busy: clear receive-end after host reads
// [RULE_07] Eight transmit bytes sent in ascending order
// [RULE_08] Ignore transmit buffer writes while busy
// [RULE_09] Software writes buffers only in interrupt service
// [RULE_10] Four receive bytes behind one address
// [RULE_11] Receive read returns zero when count zero
// [RULE_12] Software reads receive data only in service
// [RULE_13] Two base bytes give host bits 31:16
// [RULE_14] Out-of-window host addresses get no sync
// [RULE_15] Firmware cycles match select against base nibble
// [RULE_16] Base bits 19:16 ignored in decode
// [RULE_17] Software leaves base and size alone when enabled
// [RULE_18] Size field selects 1, 2, 4, 8 MB
// [RULE_19] Window never larger than attached flash
// [RULE_20] Busy indication readable while direct transfer runs
// [RULE_21] Flash address is offset masked to size
module lsfi_regs
	import lsfi_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Transfer engine side
	input  wire logic        direct_xfer_busy,
	input  wire logic [2:0]  rx_byte_count,
	input  wire logic        tx_enable_bit,
	input  wire logic        tx_byte_take,
	input  wire logic        tx_done,
	input  wire logic        rx_load,
	input  wire logic [31:0] rx_word,
	input  wire logic        host_rx_done,
	output logic [7:0]       tx_byte,
	output logic             tx_pending_flag,
	output logic             rx_data_read,
	// Host window
	input  lsfi_host_s       host,
	output lsfi_hit_s        host_hit
);

	// ==========================================================
	// Block state
	typedef struct packed {
		logic                           tx_end_flag;
		logic                           tx_end_seen;
		logic                           tx_pending_flag;
		logic                           rx_end_flag;
		logic                           rx_read_seen;
		logic [LSFI_RSV_MSB:0]          status_rsv;
		logic [LSFI_TXBUF_CNT-1:0][7:0] txbuf;
		logic [LSFI_RXBUF_CNT-1:0][7:0] rxbuf;
		logic [2:0]                     tx_ptr;
		logic [7:0]                     tx_byte;
		logic [7:0]                     base_hi;
		logic [7:0]                     base_lo;
		logic [7:0]                     size_reg;
		logic                           busy_q;
		logic                           rx_data_read;
		logic [31:0]                    hrdata;
	} lsfi_state_s;

	lsfi_state_s st_r, st_nxt;
	lsfi_req_s   req;
	logic        slv_ready;
	logic [7:0]  status_rd;
	logic [7:0]  rx_sel;
	logic [7:0]  rd_byte;
	logic [2:0]  tx_idx;
	logic        tx_hit;

	// ==========================================================
	// Bus front end
	lsfi_ahb_slave u_slave (
		.clk       (clk),
		.resetn    (resetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (slv_ready),
		.req       (req)
	);

	// ==========================================================
	// Host address window
	lsfi_host_decode u_decode (
		.clk      (clk),
		.resetn   (resetn),
		.host     (host),
		.base_hi  (st_r.base_hi),
		.base_lo  (st_r.base_lo),
		.size_sel (lsfi_size_e'(st_r.size_reg[1:0])), // RULE_18
		.hit      (host_hit)
	);

	// ==========================================================
	// Read path helpers
	always_comb begin
		status_rd = {st_r.tx_end_flag, st_r.tx_pending_flag, st_r.rx_end_flag, st_r.status_rsv};
		rx_sel    = LSFI_RST_BYTE;
		// Count N of 1 to 4 returns the byte at index N-1; zero or any count above 4 returns zero
		if (rx_byte_count != LSFI_RX_NONE && rx_byte_count <= LSFI_RX_MAX) begin
			rx_sel = st_r.rxbuf[2'(rx_byte_count - 3'h1)]; // RULE_10
		end
		tx_hit = (req.addr >= LSFI_OFS_TXBUF0) && (req.addr <= LSFI_OFS_TXBUF7);
		tx_idx = 3'(req.addr[7:LSFI_WORD_LSB] - LSFI_OFS_TXBUF0[7:LSFI_WORD_LSB]);
	end

	always_comb begin
		rd_byte = LSFI_RST_BYTE;
		if (tx_hit) begin
			rd_byte = st_r.txbuf[tx_idx];
		end else begin
			unique case (req.addr)
				LSFI_OFS_STATUS:  rd_byte = status_rd;
				LSFI_OFS_RXDATA:  rd_byte = rx_sel; // RULE_11
				LSFI_OFS_BASE_HI: rd_byte = st_r.base_hi;
				LSFI_OFS_BASE_LO: rd_byte = st_r.base_lo;
				LSFI_OFS_SIZE:    rd_byte = st_r.size_reg;
				LSFI_OFS_XSTATE:  rd_byte = {7'h00, st_r.busy_q}; // RULE_20
				default:          rd_byte = LSFI_RST_BYTE;
			endcase
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt              = st_r;
		st_nxt.busy_q       = direct_xfer_busy;
		st_nxt.rx_data_read = 1'b0;

		// Register reads; data stands until the next read
		if (req.rd) begin
			st_nxt.hrdata = {24'h000000, rd_byte};
			if (req.addr == LSFI_OFS_STATUS && st_r.tx_end_flag) begin
				st_nxt.tx_end_seen = 1'b1; // RULE_02
			end
			if (req.addr == LSFI_OFS_RXDATA) begin
				st_nxt.rx_data_read = 1'b1;
				st_nxt.rx_read_seen = 1'b1;
			end
		end

		// Register writes
		if (req.wr) begin
			if (tx_hit && !direct_xfer_busy) begin
				st_nxt.txbuf[tx_idx] = req.wdata[7:0]; // RULE_08
			end
			unique case (req.addr)
				LSFI_OFS_STATUS: begin
					st_nxt.status_rsv = req.wdata[LSFI_RSV_MSB:0];
					// Writing one leaves the flag alone
					if (!req.wdata[LSFI_BIT_TX_END] && st_r.tx_end_seen) begin
						st_nxt.tx_end_flag = 1'b0; // RULE_02
						st_nxt.tx_end_seen = 1'b0;
					end
				end
				LSFI_OFS_BASE_HI: st_nxt.base_hi  = req.wdata[7:0]; // RULE_13
				LSFI_OFS_BASE_LO: st_nxt.base_lo  = req.wdata[7:0]; // RULE_13
				LSFI_OFS_SIZE:    st_nxt.size_reg = req.wdata[7:0];
				default: begin
				end
			endcase
		end

		// Receive-end clearing, depending on who drains the data
		if (st_r.rx_end_flag) begin
			if (!direct_xfer_busy && st_r.rx_read_seen && rx_byte_count == LSFI_RX_NONE) begin
				st_nxt.rx_end_flag  = 1'b0; // RULE_05
				st_nxt.rx_read_seen = 1'b0;
			end
			if (direct_xfer_busy && host_rx_done) begin
				st_nxt.rx_end_flag  = 1'b0; // RULE_06
				st_nxt.rx_read_seen = 1'b0;
			end
		end

		// Receive load; set wins over any clear in the same cycle
		if (rx_load) begin
			st_nxt.rxbuf        = rx_word;
			st_nxt.rx_end_flag  = 1'b1; // RULE_04
			st_nxt.rx_read_seen = 1'b0;
		end

		// Transmit byte stream, pointer holds at the last buffer
		if (tx_byte_take && st_r.tx_ptr != LSFI_TX_LAST) begin
			st_nxt.tx_ptr = st_r.tx_ptr + 3'h1; // RULE_07
		end
		if (tx_enable_bit) begin
			st_nxt.tx_pending_flag = 1'b1; // RULE_03
			st_nxt.tx_ptr          = 3'h0; // RULE_07
		end
		st_nxt.tx_byte = st_nxt.txbuf[st_nxt.tx_ptr]; // RULE_07

		if (tx_done) begin
			st_nxt.tx_pending_flag = 1'b0; // RULE_03
			st_nxt.tx_end_flag     = 1'b1; // RULE_01
			st_nxt.tx_end_seen     = 1'b0;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs, all from flops except hresp, which is tied low
	assign hreadyout       = slv_ready;
	assign hresp           = 1'b0;
	assign hrdata          = st_r.hrdata;
	assign tx_byte         = st_r.tx_byte;
	assign tx_pending_flag = st_r.tx_pending_flag;
	assign rx_data_read    = st_r.rx_data_read;

endmodule : lsfi_regs

// [lsfi_regs_props.sv]
`timescale 1ns/1ps
// ==========
// Port checker
module lsfi_regs_props
	import lsfi_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        tx_enable_bit,
	input wire logic        tx_done,
	input wire logic        rx_load,
	input wire logic [31:0] rx_word,
	input wire logic [2:0]  rx_byte_count,
	input wire logic        rx_data_read,
	input wire logic        tx_pending_flag,
	input lsfi_host_s       host,
	input lsfi_hit_s        host_hit
);
	logic        take;
	logic        rx_req;
	logic [31:0] rxw_r;
	assign take   = hsel && htrans[1] && hready;
	assign rx_req = take && !hwrite && (haddr[7:0] == LSFI_OFS_RXDATA);
	// Shadow of the last received word, for the byte select check
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxw_r <= '0;
		end else if (rx_load) begin
			rxw_r <= rx_word;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	AST_PEND_SET: assert property (tx_enable_bit |=> tx_pending_flag)
		else $error("pending flag not set");
	AST_PEND_CLR: assert property (tx_done && !tx_enable_bit |=> !tx_pending_flag)
		else $error("pending flag not cleared");
	AST_PEND_HOLD: assert property (tx_pending_flag && !tx_done |=> tx_pending_flag)
		else $error("pending flag dropped early");
	AST_READY: assert property (take |=> !hreadyout ##1 hreadyout)
		else $error("bad wait state");
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("error response");
	AST_SYNC: assert property (host_hit.sync |-> $past(host.valid))
		else $error("sync without request");
	AST_RX_ZERO: assert property (rx_data_read && rx_byte_count == LSFI_RX_NONE |-> hrdata == 32'h0)
		else $error("rx read not zero");
	AST_RX_SEL: assert property (rx_data_read && rx_byte_count inside {[3'h1:3'h4]}
		|-> hrdata == {24'h0, rxw_r[8*(rx_byte_count-1) +: 8]})
		else $error("wrong rx byte");
	AST_RX_CAUSE: assert property (rx_data_read |-> $past(rx_req, 2))
		else $error("stray rx read pulse");
	cover property (tx_done);
	cover property (host_hit.sync);
	cover property (rx_data_read && rx_byte_count == 3'h4);
endmodule : lsfi_regs_props

bind lsfi_regs lsfi_regs_props lsfi_regs_props_i (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata, .tx_enable_bit, .tx_done, .rx_load, .rx_word, .rx_byte_count, .rx_data_read,
	.tx_pending_flag, .host, .host_hit);

// [lsfi_engine_model.sv]
`timescale 1ns/1ps
// ==========
// Transfer engine stand-in; takes a byte every other cycle
module lsfi_engine_model
	import lsfi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       start,
	input  wire logic [3:0] nbytes,
	input  wire logic [7:0] tx_byte,
	input  wire logic       rx_fill,
	input  wire logic [2:0] rx_n,
	input  wire logic       rx_data_read,
	output logic            tx_enable_bit,
	output logic            tx_byte_take,
	output logic            tx_done,
	output logic            rx_load,
	output logic [2:0]      rx_byte_count,
	output logic [7:0][7:0] got
);
	logic       act_r;
	logic [3:0] cnt_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{act_r, cnt_r, tx_enable_bit, tx_byte_take, tx_done, rx_load, rx_byte_count} <= '0;
			got <= '0;
		end else begin
			tx_enable_bit <= start;
			tx_byte_take  <= 1'b0;
			tx_done       <= 1'b0;
			rx_load       <= rx_fill;
			if (tx_enable_bit) begin
				act_r <= 1'b1;
				cnt_r <= 4'h0;
			end else if (act_r && !tx_byte_take) begin
				if (cnt_r == nbytes) begin
					tx_done <= 1'b1;
					act_r   <= 1'b0;
				end else begin
					got[cnt_r[2:0]] <= tx_byte;
					tx_byte_take    <= 1'b1;
					cnt_r           <= cnt_r + 4'h1;
				end
			end
			// Count steps down per controller read, as the real engine does
			if (rx_fill) begin
				rx_byte_count <= rx_n;
			end else if (rx_data_read && rx_byte_count != 3'h0) begin
				rx_byte_count <= rx_byte_count - 3'h1;
			end
		end
	end
endmodule : lsfi_engine_model

// [tb.sv]
`timescale 1ns/1ps
module tb
	import lsfi_pkg::*;
;
	logic            clk, resetn, hsel, hwrite, busy, host_rx_done, start, rx_fill;
	logic            hreadyout, hresp, tx_enable_bit, tx_byte_take, tx_done, rx_load, tx_pending_flag, rx_data_read;
	logic [31:0]     haddr, hwdata, hrdata, rx_word, rd;
	logic [1:0]      htrans;
	logic [2:0]      hsize, rx_n, rx_byte_count;
	logic [3:0]      nbytes;
	logic [7:0]      tx_byte;
	logic [7:0][7:0] got;
	lsfi_host_s      host;
	lsfi_hit_s       host_hit;
	int              fail_count, checks_done, cyc;

	always #10 clk = ~clk;

	lsfi_regs lsfi_regs_i (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .direct_xfer_busy(busy), .rx_byte_count, .tx_enable_bit, .tx_byte_take,
		.tx_done, .rx_load, .rx_word, .host_rx_done, .tx_byte, .tx_pending_flag, .rx_data_read, .host, .host_hit);
	lsfi_engine_model lsfi_engine_model_i (.clk, .resetn, .start, .nbytes, .tx_byte, .rx_fill, .rx_n,
		.rx_data_read, .tx_enable_bit, .tx_byte_take, .tx_done, .rx_load, .rx_byte_count, .got);

	// ==========
	// Tasks
	task automatic tally_and_finish();
		if (fail_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc

	task automatic hst(input logic fw, input logic [3:0] id, input logic [31:0] a, input logic s,
		input logic [22:0] f);
		host <= {1'b1, fw, id, a};
		@(posedge clk);
		host.valid <= 1'b0;
		@(posedge clk);
		// Address of a miss is left open, so only sync is compared then
		chk({8'h0, host_hit.sync, host_hit.faddr & {23{s}}}, {8'h0, s, f & {23{s}}});
	endtask : hst

	task automatic tx_run(input logic [3:0] n);
		nbytes <= n;
		start  <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		do @(posedge clk); while (tx_done !== 1'b1);
		@(posedge clk);
	endtask : tx_run

	task automatic fill();
		rx_fill <= 1'b1;
		@(posedge clk);
		rx_fill <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : fill

	// ==========
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			fail_count++;
			$display("MISMATCH %0t timeout", $time);
			tally_and_finish();
		end
	end

	// ==========
	// Main sequence
	initial begin
		{clk, hsel, hwrite, busy, host_rx_done, start, rx_fill, haddr, hwdata, htrans, nbytes, host} = '0;
		hsize   = 3'h2;
		rx_word = 32'h44332211;
		rx_n    = 3'h4;
		resetn  = 1'b0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 16; i++) rdc(8'(4*i), 32'h0);
		for (int i = 0; i < 8; i++) ahb(1'b1, 8'(4*i+4), {24'h0, 8'(8'h11*i+8'h0f)});
		ahb(1'b1, 8'h3c, 32'hff);
		ahb(1'b1, LSFI_OFS_STATUS, 32'h1f);
		rdc(LSFI_OFS_STATUS, 32'h1f);
		ahb(1'b1, LSFI_OFS_STATUS, 32'h0);
		rdc(8'h3c, 32'h0);
		tx_run(4'h8);
		for (int i = 0; i < 8; i++) chk({24'h0, got[i]}, {24'h0, 8'(8'h11*i+8'h0f)});
		rdc(LSFI_OFS_STATUS, 32'h80);
		ahb(1'b1, LSFI_OFS_STATUS, 32'h80);
		rdc(LSFI_OFS_STATUS, 32'h80);
		ahb(1'b1, LSFI_OFS_STATUS, 32'h0);
		rdc(LSFI_OFS_STATUS, 32'h0);
		tx_run(4'h1);
		ahb(1'b1, LSFI_OFS_STATUS, 32'h0);
		rdc(LSFI_OFS_STATUS, 32'h80);
		ahb(1'b1, LSFI_OFS_STATUS, 32'h0);
		rdc(LSFI_OFS_STATUS, 32'h0);
		busy <= 1'b1;
		rdc(LSFI_OFS_XSTATE, 32'h1);
		ahb(1'b1, LSFI_OFS_TXBUF0, 32'h77);
		busy <= 1'b0;
		rdc(LSFI_OFS_TXBUF0, 32'h0f);
		rdc(LSFI_OFS_XSTATE, 32'h0);
		fill();
		rdc(LSFI_OFS_STATUS, 32'h20);
		for (int i = 4; i > 0; i--) rdc(LSFI_OFS_RXDATA, {24'h0, 8'(8'h11*i)});
		rdc(LSFI_OFS_STATUS, 32'h0);
		rdc(LSFI_OFS_RXDATA, 32'h0);
		busy <= 1'b1;
		fill();
		rdc(LSFI_OFS_STATUS, 32'h20);
		host_rx_done <= 1'b1;
		@(posedge clk);
		host_rx_done <= 1'b0;
		rdc(LSFI_OFS_STATUS, 32'h0);
		busy <= 1'b0;
		ahb(1'b1, LSFI_OFS_BASE_HI, 32'h12);
		ahb(1'b1, LSFI_OFS_BASE_LO, 32'h35);
		rdc(LSFI_OFS_BASE_LO, 32'h35);
		for (int s = 0; s < 4; s++) begin
			ahb(1'b1, LSFI_OFS_SIZE, 32'(s));
			hst(1'b0, 4'h0, 32'h12300000 + (32'h100000 << s) - 32'h1, 1'b1, 23'((32'h100000 << s) - 1));
			hst(1'b0, 4'h0, 32'h12300000 + (32'h100000 << s), 1'b0, 23'h0);
		end
		hst(1'b0, 4'h0, 32'h122fffff, 1'b0, 23'h0);
		hst(1'b0, 4'h0, 32'h12345678, 1'b1, 23'h045678);
		hst(1'b1, 4'h1, 32'h02345678, 1'b1, 23'h045678);
		hst(1'b1, 4'h2, 32'h02345678, 1'b0, 23'h0);
		tally_and_finish();
	end
endmodule : tb
